/* File: logic/crcgen_consts.vh */
// Constants for the CRC-16 byte generator: offsets, fields, resets, responses, FIFO shape
`ifndef CRCGEN_CONSTS_VH
`define CRCGEN_CONSTS_VH

// ==========================================================================
// Register byte offsets (one aligned 32-bit word each)
`define CRCGEN_OFS_HIGH 8'h00
`define CRCGEN_OFS_LOW 8'h04
`define CRCGEN_OFS_STATUS 8'h08
`define CRCGEN_OFS_MODE 8'h0c

// ==========================================================================
// Field positions and values
`define CRCGEN_POLY 16'h1021
`define CRCGEN_CRC_RESET 16'h0000
`define CRCGEN_BYTE_BITS 4'h8
`define CRCGEN_MODE_RUN 2'h0
`define CRCGEN_MODE_WAIT 2'h1
`define CRCGEN_MODE_LSTOP 2'h2
`define CRCGEN_MODE_DSTOP 2'h3
`define CRCGEN_ST_ARMED 0
`define CRCGEN_ST_BUSY 1
`define CRCGEN_ST_FEMPTY 2
`define CRCGEN_ST_FFULL 3

// ==========================================================================
// AXI4-Lite responses
`define CRCGEN_RESP_OKAY 2'h0
`define CRCGEN_RESP_SLVERR 2'h2

// ==========================================================================
// FIFO shape
`define CRCGEN_FIFO_DEPTH 32
`define CRCGEN_FIFO_AW 5

`endif

/* File: logic/crcgen_fifo.v */
// Byte queue module lives beside the top level in crcgen_top.v

/* File: logic/crcgen_top.v */
// CRC-16 (poly 0x1021) byte generator with AXI4-Lite register slave
//
// The address map and the AXI4-Lite register port were left to the implementer.
`include "crcgen_consts.vh"
`default_nettype none

// Summary of operation
// RULE1 - Sixteen-bit CRC, polynomial 0x1021, shift register
// RULE2 - High write loads bits 15-8, arms seed
// RULE3 - Armed low write loads bits 7-0, disarms
// RULE4 - Unarmed low write shifts eight bits, MSB first
// RULE5 - Result readable the cycle after data
// RULE6 - High read returns bits 15-8
// RULE7 - Low read returns bits 7-0
// RULE8 - Each byte continues from previous CRC value
// RULE9 - High write restarts seed sequence anytime
// RULE10 - No augmentation, no final complement
// RULE11 - Matches published reference check values
// RULE12 - Software writes seed high, low, data
// RULE13 - Deep stop halts, returns reset state
// RULE14 - Light stop freezes, resumes on run
// RULE15 - Reset clears CRC and seed arm
module crcgen_top (
  input wire sys_clk_in,
  input wire srst_in,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in
);
  // ========================================================================
  // Write channel capture
  reg [7:0] aw_addr_r; // Held write address
  reg aw_have_r; // Write address captured
  reg [31:0] w_data_r; // Held write data
  reg w_strb0_r; // Low byte lane strobe
  reg w_have_r; // Write data captured
  wire wr_go; // Both halves present, response free
  reg wr_blocked; // Write waits on FIFO space

  // ========================================================================
  // Core state
  reg [15:0] crc_r; // CRC shift register
  reg [15:0] crc_nxt;
  reg armed_r; // Seed low byte expected next
  reg armed_nxt;
  reg [1:0] mode_r; // Power mode control
  reg [1:0] mode_prev_r; // Mode seen last cycle
  wire halted; // Either stop mode freezes the engine
  wire dstop_exit; // Leaving deep stop

  // ========================================================================
  // Byte FIFO: {is_high, byte}; commands kept in order
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire [8:0] fifo_in_data;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [8:0] fifo_out_data;
  wire fifo_empty;
  wire fifo_full;

  // ========================================================================
  // Address decode for the captured write
  reg wr_to_high;
  reg wr_to_low;
  reg wr_to_mode;
  reg wr_bad;
  always @* begin
    wr_to_high = 1'b0;
    wr_to_low = 1'b0;
    wr_to_mode = 1'b0;
    wr_bad = 1'b0;
    // Word-aligned compare: byte lane bits forced to zero
    if ({aw_addr_r[7:2], 2'b00} == `CRCGEN_OFS_HIGH) begin
      wr_to_high = 1'b1;
    end else if ({aw_addr_r[7:2], 2'b00} == `CRCGEN_OFS_LOW) begin
      wr_to_low = 1'b1;
    end else if ({aw_addr_r[7:2], 2'b00} == `CRCGEN_OFS_MODE) begin
      wr_to_mode = 1'b1;
    end else if ({aw_addr_r[7:2], 2'b00} == `CRCGEN_OFS_STATUS) begin
      wr_to_mode = 1'b0; // Status is read only, write ignored
    end else begin
      wr_bad = 1'b1;
    end
  end

  // Byte writes into CRC registers go through the FIFO; a full FIFO stalls
  // the bus write, so back-pressure reaches the master.
  always @* begin
    wr_blocked = (wr_to_high | wr_to_low) & w_strb0_r & ~fifo_in_ready;
  end
  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid_out & ~wr_blocked;
  assign fifo_in_valid = aw_have_r & w_have_r & ~s_axi_bvalid_out &
    (wr_to_high | wr_to_low) & w_strb0_r;
  assign fifo_in_data = {wr_to_high, w_data_r[7:0]};

  // ========================================================================
  // AXI write side: accept address and data in either order
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb0_r <= 1'b0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `CRCGEN_RESP_OKAY;
    end else begin
      // Ready is one-cycle pulse taking the item
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      if (s_axi_awvalid_in & ~aw_have_r & ~s_axi_awready_out) begin
        s_axi_awready_out <= 1'b1;
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in & ~w_have_r & ~s_axi_wready_out) begin
        s_axi_wready_out <= 1'b1;
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata_in;
        w_strb0_r <= s_axi_wstrb_in[0];
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_bad ? `CRCGEN_RESP_SLVERR :
          `CRCGEN_RESP_OKAY;
      end else if (s_axi_bvalid_out & s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Mode register; deep stop entry/exit handled in core
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      mode_r <= `CRCGEN_MODE_RUN;
      mode_prev_r <= `CRCGEN_MODE_RUN;
    end else begin
      mode_prev_r <= mode_r;
      if (wr_go & wr_to_mode & w_strb0_r) begin
        mode_r <= w_data_r[1:0];
      end
    end
  end
  assign halted = (mode_r == `CRCGEN_MODE_LSTOP) |
    (mode_r == `CRCGEN_MODE_DSTOP); // [RULE13] [RULE14]
  assign dstop_exit = (mode_prev_r == `CRCGEN_MODE_DSTOP) &
    (mode_r != `CRCGEN_MODE_DSTOP);

  // ========================================================================
  // FIFO instance between bus and CRC engine
  crcgen_fifo #(
    .WIDTH(9),
    .DEPTH(`CRCGEN_FIFO_DEPTH),
    .AW(`CRCGEN_FIFO_AW)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data),
    .empty_out(fifo_empty),
    .full_out(fifo_full)
  );
  // Engine drains one byte per cycle unless stopped; the queue also
  // waits while deep-stop exit clears the engine, or a byte is lost
  assign fifo_out_ready = ~halted & ~dstop_exit; // [RULE14] [RULE13]

  // ========================================================================
  // CRC engine: eight MSB-first steps in one cycle, no augmentation and
  // no complement, so the register holds the raw remainder.
  always @* begin : crc_step
    integer i;
    reg fb;
    i = 0;
    crc_nxt = crc_r;
    armed_nxt = armed_r;
    fb = 1'b0;
    if (fifo_out_valid & fifo_out_ready) begin
      if (fifo_out_data[8]) begin
        crc_nxt = {fifo_out_data[7:0], crc_r[7:0]}; // [RULE2]
        armed_nxt = 1'b1; // [RULE9]
      end else if (armed_r) begin
        crc_nxt = {crc_r[15:8], fifo_out_data[7:0]}; // [RULE3]
        armed_nxt = 1'b0;
      end else begin
        // Start from previous value, byte MSB first [RULE4] [RULE8]
        for (i = 7; i >= 0; i = i - 1) begin
          fb = crc_nxt[15] ^ fifo_out_data[i];
          crc_nxt = {crc_nxt[14:0], 1'b0} ^
            (fb ? `CRCGEN_POLY : 16'h0000); // [RULE1] [RULE10] [RULE11]
        end
      end
    end
  end

  // Register update; deep-stop exit returns to reset contents
  always @(posedge sys_clk_in) begin
    if (srst_in | dstop_exit) begin
      crc_r <= `CRCGEN_CRC_RESET; // [RULE15] [RULE13]
      armed_r <= 1'b0;
    end else begin
      crc_r <= crc_nxt; // [RULE5]
      armed_r <= armed_nxt;
    end
  end

  // ========================================================================
  // AXI read side: data returned in the same cycle the address is taken
  reg [31:0] rd_word; // Decoded read value
  reg rd_bad;
  always @* begin
    rd_word = 32'h00000000;
    rd_bad = 1'b0;
    if ({s_axi_araddr_in[7:2], 2'b00} == `CRCGEN_OFS_HIGH) begin
      rd_word = {24'h000000, crc_r[15:8]}; // [RULE6]
    end else if ({s_axi_araddr_in[7:2], 2'b00} == `CRCGEN_OFS_LOW) begin
      rd_word = {24'h000000, crc_r[7:0]}; // [RULE7]
    end else if ({s_axi_araddr_in[7:2], 2'b00} == `CRCGEN_OFS_STATUS) begin
      rd_word = {28'h0000000, fifo_full, fifo_empty, ~fifo_empty, armed_r};
    end else if ({s_axi_araddr_in[7:2], 2'b00} == `CRCGEN_OFS_MODE) begin
      rd_word = {30'h0, mode_r};
    end else begin
      rd_bad = 1'b1;
    end
  end

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= `CRCGEN_RESP_OKAY;
    end else begin
      s_axi_arready_out <= 1'b0;
      if (s_axi_arvalid_in & ~s_axi_rvalid_out & ~s_axi_arready_out) begin
        // Reads wait for queued bytes outside the stop modes, so there a read
        // after a data write always sees that byte's result
        if (fifo_empty | halted) begin
          s_axi_arready_out <= 1'b1;
          s_axi_rvalid_out <= 1'b1;
          s_axi_rdata_out <= rd_word;
          s_axi_rresp_out <= rd_bad ? `CRCGEN_RESP_SLVERR :
            `CRCGEN_RESP_OKAY;
        end
      end else if (s_axi_rvalid_out & s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end
endmodule // crcgen_top

// ==========================================================================
// Synchronous valid/ready FIFO built from flip-flops
module crcgen_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire sys_clk_in,
  input wire srst_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire empty_out,
  output wire full_out
);
  // ========================================================================
  // Storage and pointers
  reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // Entry storage
  reg [AW-1:0] wptr_r; // Write index
  reg [AW-1:0] rptr_r; // Read index
  reg [AW:0] count_r; // Occupancy, one bit wider than index
  wire push; // Entry accepted this cycle
  wire pop; // Entry drained this cycle

  assign full_out = (count_r == DEPTH[AW:0]);
  assign empty_out = (count_r == {(AW+1){1'b0}});
  assign in_ready_out = ~full_out;
  assign out_valid_out = ~empty_out;
  assign out_data_out = mem_r[rptr_r];
  assign push = in_valid_in & ~full_out;
  assign pop = out_ready_in & ~empty_out;

  // ========================================================================
  // Pointer and count update
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rptr_r + 1'b1;
      end
      // Simultaneous push and pop keeps count
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // Data array has no reset; only valid entries are ever read
  always @(posedge sys_clk_in) begin
    if (push) begin
      mem_r[wptr_r] <= in_data_in;
    end
  end
endmodule // crcgen_fifo

`default_nettype wire

/* File: testbench/crcgen_monitor.sv */
// Bus handshake and reset checks on the CRC generator top ports
`default_nettype none

// ==========================================================
// Checker module
module crcgen_monitor (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so one default for all
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // Response held with its code until taken
  property p_bhold;
    s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  // Read data frozen until taken
  property p_rhold;
    s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rdata moved");
  // Byte registers leave upper lanes zero
  property p_rdz;
    s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0;
  endproperty
  a_rdz: assert property (p_rdz) else $error("upper rdata set");
  // Nothing answered in the cycle reset is released
  property p_rst;
    $fell(srst_in) |-> !s_axi_bvalid_out && !s_axi_rvalid_out;
  endproperty
  a_rst: assert property (p_rst) else $error("valid in reset");
  // A taken write is answered within a bounded time
  property p_bbound;
    s_axi_awvalid_in && s_axi_awready_out |-> ##[1:80] s_axi_bvalid_out;
  endproperty
  a_bbound: assert property (p_bbound) else $error("no bvalid");
  // Read data comes with the address handshake
  property p_arr;
    s_axi_arready_out |-> s_axi_rvalid_out;
  endproperty
  a_arr: assert property (p_arr) else $error("rvalid late");
  // Ready pulses only for a pending request, one cycle
  property p_awp;
    s_axi_awready_out |-> s_axi_awvalid_in ##1 !s_axi_awready_out;
  endproperty
  a_awp: assert property (p_awp) else $error("awready bad");
  property p_wp;
    s_axi_wready_out |-> s_axi_wvalid_in ##1 !s_axi_wready_out;
  endproperty
  a_wp: assert property (p_wp) else $error("wready bad");
endmodule // crcgen_monitor
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the CRC-16 byte generator
`include "crcgen_consts.vh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 0;
  logic rst = 1;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] strb = 4'hf;
  logic awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
  wire awrdy, wrdy, bv, arrdy, rv;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer errors = 0;
  integer check_count = 0;
  logic [15:0] c, v, h;
  logic [31:0] t;
  logic [71:0] msg = "123456789";
  integer i, s;
  // 250 MHz
  always #2 clk = ~clk;
  // Lane 0 strobe set unless a test clears it
  crcgen_top i_crcgen_top (.sys_clk_in(clk), .srst_in(rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awrdy), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arrdy), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy));
  // ==========================================================
  // Bus tasks and reference
  task chk(input string n, input [31:0] e, input [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      errors++;
    end
  endtask
  // Both channels offered together, each dropped when taken
  task wr(input [7:0] a, input [7:0] d, input [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    brdy <= 1;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv);
    chk("bresp", er, bresp);
    brdy <= 0;
  endtask
  task rd(input [7:0] a, output [31:0] d);
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rrdy <= 1;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 0;
    end while (!rv);
    d = rdata;
    rrdy <= 0;
  endtask
  task rd16(output [15:0] r);
    rd(`CRCGEN_OFS_HIGH, t);
    r[15:8] = t[7:0];
    rd(`CRCGEN_OFS_LOW, t);
    r[7:0] = t[7:0];
  endtask
  // Bitwise model, MSB first, no augmentation
  function automatic [15:0] cref(input [15:0] x, input [7:0] b);
    for (int k = 7; k >= 0; k--)
      x = {x[14:0], 1'b0} ^ ((x[15] ^ b[k]) ? `CRCGEN_POLY : 16'h0);
    return x;
  endfunction
  task put(input [7:0] b);
    wr(`CRCGEN_OFS_LOW, b, 2'h0);
    c = cref(c, b);
    rd16(v);
    chk("crc", c, v);
  endtask
  task seed(input [15:0] sd);
    wr(`CRCGEN_OFS_HIGH, sd[15:8], 2'h0);
    wr(`CRCGEN_OFS_LOW, sd[7:0], 2'h0);
    c = sd;
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    rd16(v);
    chk("rst", 0, v);
    c = 0;
    put(8'h41);
    chk("A", 16'h58e5, v);
    $display("t_reset done");
  endtask
  task t_vec;
    for (s = 0; s < 2; s++) begin
      seed(s ? 16'hffff : 16'h0);
      for (i = 0; i < 9; i++)
        put(msg[71-8*i -: 8]);
      chk("vec", s ? 16'h29b1 : 16'h31c3, v);
    end
    seed(16'hffff);
    put(8'h41);
    chk("Aff", 16'hb915, v);
    $display("t_vec done");
  endtask
  task t_seed;
    seed(16'h1234);
    put(8'h55);
    wr(`CRCGEN_OFS_HIGH, 8'hab, 2'h0);
    rd(`CRCGEN_OFS_HIGH, t);
    chk("hi", 8'hab, t);
    seed(16'hcdef);
    rd16(v);
    chk("seed", 16'hcdef, v);
    put(8'h00);
    wr(8'h10, 8'h5a, `CRCGEN_RESP_SLVERR);
    wr(`CRCGEN_OFS_STATUS, 8'hff, 2'h0);
    rd16(v);
    chk("kept", c, v);
    $display("t_seed done");
  endtask
  // Light stop fills the queue, run drains it
  task t_mode;
    wr(`CRCGEN_OFS_MODE, `CRCGEN_MODE_WAIT, 2'h0);
    put(8'h3c);
    h = c;
    wr(`CRCGEN_OFS_MODE, `CRCGEN_MODE_LSTOP, 2'h0);
    for (i = 0; i < 32; i++) begin
      wr(`CRCGEN_OFS_LOW, i[7:0], 2'h0);
      c = cref(c, i[7:0]);
    end
    rd16(v);
    chk("held", h, v);
    rd(`CRCGEN_OFS_STATUS, t);
    chk("full", 2'h2, t[3:2]);
    wr(`CRCGEN_OFS_MODE, `CRCGEN_MODE_RUN, 2'h0);
    rd16(v);
    chk("resume", c, v);
    rd(`CRCGEN_OFS_STATUS, t);
    chk("empty", 2'h1, t[3:2]);
    wr(`CRCGEN_OFS_MODE, `CRCGEN_MODE_DSTOP, 2'h0);
    wr(`CRCGEN_OFS_MODE, `CRCGEN_MODE_RUN, 2'h0);
    rd16(v);
    chk("deep", 0, v);
    c = 0;
    put(8'h41);
    $display("t_mode done");
  endtask
  // Late ready on both answers, lane strobe clear, unmapped read
  task t_slow;
    @(posedge clk);
    awaddr <= `CRCGEN_OFS_HIGH;
    wdata <= 32'h0000005a;
    strb <= 4'he;
    awv <= 1;
    wv <= 1;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv);
    repeat (2) @(posedge clk);
    brdy <= 1;
    @(posedge clk);
    chk("bhold", 1, bv);
    chk("bresp", `CRCGEN_RESP_OKAY, bresp);
    brdy <= 0;
    strb <= 4'hf;
    rd16(v);
    chk("nolane", c, v);
    rd(`CRCGEN_OFS_STATUS, t);
    chk("unarmed", 0, t[0]);
    wr(`CRCGEN_OFS_HIGH, 8'h12, 2'h0);
    rd(`CRCGEN_OFS_STATUS, t);
    chk("armed", 1, t[0]);
    wr(`CRCGEN_OFS_LOW, 8'h34, 2'h0);
    rd16(v);
    chk("seed2", 16'h1234, v);
    @(posedge clk);
    araddr <= `CRCGEN_OFS_MODE;
    arv <= 1;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 0;
    end while (!rv);
    t = rdata;
    repeat (2) @(posedge clk);
    rrdy <= 1;
    @(posedge clk);
    chk("rhold", t, rdata);
    chk("mode", `CRCGEN_MODE_RUN, t);
    rrdy <= 0;
    rd(8'h10, t);
    chk("rresp", `CRCGEN_RESP_SLVERR, rresp);
    chk("rzero", 0, t);
    $display("t_slow done");
  endtask
  // ==========================================================
  // Sequence, watchdog and verdict
  task close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_reset;
    t_vec;
    t_seed;
    t_mode;
    t_slow;
    close_out;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    close_out;
  end
endmodule // tb_top

bind crcgen_top crcgen_monitor i_crcgen_monitor (.sys_clk_in, .srst_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rvalid_out, .s_axi_rready_in);
`default_nettype wire
